// ==== pmx_port0_mux.sv ====
`timescale 1ns/100ps
// Notes on behaviour
// (RULE1) code 0 port, codes 1 to 25 select peripherals
// (RULE2) code 15 analog input, low four pins only
// (RULE3) code 18 drives radio diagnostic onto pin
// (RULE4) duplicated input taken from lowest pin index
// (RULE5) port zero pins beat port one pins
// (RULE6) pull 00: input, no resistor
// (RULE7) pull 01: input with pull-up
// (RULE8) pull 10: input with pull-down
// (RULE9) pull 11: output, no resistor
// (RULE10) analog selection ignores the pull field
// (RULE11) reset: port, pulled down; reserved bits zero
module pmx_port0_mux #(
  parameter int PINS = 4,
  parameter int ANALOG_PINS = 4
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [31:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic [PINS-1:0] pad_in,
  output pmx_pkg::pmx_pad_t [PINS-1:0] pad_ctl,
  input wire logic [PINS-1:0] port_out_data,
  output logic [PINS-1:0] port_in_data,
  input wire logic [31:0] periph_drive,
  input wire logic [PINS-1:0] radio_diag_output,
  input wire logic [31:0] port_one_claim,
  input wire logic [31:0] port_one_value,
  output logic [31:0] periph_sample,
  output logic [31:0] periph_claimed
);
  import pmx_pkg::*;

  // reset synchroniser stages
  logic rst_meta_r;
  logic rst_n_q;
  // mode registers, one entry per pin, each written by its own process
  pmx_mode_t mode_r [PINS-1:0];
  // pin input synchroniser stages
  logic [PINS-1:0] pin_meta_r;
  logic [PINS-1:0] pin_q_r;
  // read data next value
  logic [15:0] rdata_nxt;
  // pad control next values
  pmx_pad_t [PINS-1:0] pad_nxt;
  // peripheral input arbitration results
  logic [31:0] sample_nxt;
  logic [31:0] claim_nxt;

  // release of reset through two flops
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rst_meta_r <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n_q <= rst_meta_r;
    end
  end

  // two-flop synchroniser on the pad inputs
  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      pin_meta_r <= '0;
      pin_q_r <= '0;
    end else begin
      pin_meta_r <= pad_in;
      pin_q_r <= pin_meta_r;
    end
  end

  // port data as seen on the pins
  assign port_in_data = pin_q_r;

  // mode register writes, one register per pin
  genvar gi;
  generate
    for (gi = 0; gi < PINS; gi++) begin : g_mode
      // address of this pin's register
      localparam logic [31:0] OFF = PMX_OFF_PIN0_MODE + PMX_OFF_STEP * gi;
      always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
          // port function, pulled-down input
          mode_r[gi].func <= PMX_RST_FUNC; // [RULE11]
          mode_r[gi].pull <= PMX_RST_PULL; // [RULE11]
        end else if (reg_wr && reg_addr == OFF) begin
          // reserved bits are dropped on write
          mode_r[gi].func <= reg_wdata[PMX_FUNC_MSB:PMX_FUNC_LSB]; // [RULE11]
          mode_r[gi].pull <= reg_wdata[PMX_PULL_MSB:PMX_PULL_LSB];
        end
      end
    end
  endgenerate

  // read decode; unmapped addresses and reserved bits read zero
  always_comb begin
    rdata_nxt = '0;
    for (int i = 0; i < PINS; i++) begin
      if (reg_addr == PMX_OFF_PIN0_MODE + PMX_OFF_STEP * i) begin
        rdata_nxt[PMX_FUNC_MSB:PMX_FUNC_LSB] = mode_r[i].func; // [RULE11]
        rdata_nxt[PMX_PULL_MSB:PMX_PULL_LSB] = mode_r[i].pull;
      end
    end
  end

  // read data stands in the cycle after the strobe only
  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      reg_rdata <= rdata_nxt;
    end else begin
      reg_rdata <= '0;
    end
  end

  // pad control per pin from its mode
  always_comb begin
    for (int i = 0; i < PINS; i++) begin
      // default: input with the resistor the pull field asks for
      pad_nxt[i].dout = 1'b0;
      pad_nxt[i].oe_n = 1'b1;
      pad_nxt[i].analog_sel = 1'b0;
      pad_nxt[i].pull_up = (mode_r[i].pull == PMX_PULL_UP); // [RULE6] [RULE7]
      pad_nxt[i].pull_down = (mode_r[i].pull == PMX_PULL_DOWN); // [RULE6] [RULE8]
      if (mode_r[i].func == PMX_FN_PORT) begin
        if (mode_r[i].pull == PMX_PULL_OUT) begin
          // port output, no resistor
          pad_nxt[i].dout = port_out_data[i]; // [RULE1] [RULE9]
          pad_nxt[i].oe_n = 1'b0; // [RULE9]
        end
      end else if (mode_r[i].func == PMX_FN_ANALOG) begin
        if (i < ANALOG_PINS) begin
          // analog input: pull field has no effect at all
          pad_nxt[i].analog_sel = 1'b1; // [RULE2]
          pad_nxt[i].pull_up = 1'b0; // [RULE10]
          pad_nxt[i].pull_down = 1'b0; // [RULE10]
        end
      end else if (mode_r[i].func == PMX_FN_DIAG) begin
        // radio diagnostic line driven out, resistors off
        pad_nxt[i].dout = radio_diag_output[i]; // [RULE3]
        pad_nxt[i].oe_n = 1'b0; // [RULE3]
        pad_nxt[i].pull_up = 1'b0;
        pad_nxt[i].pull_down = 1'b0;
      end else if (mode_r[i].func <= PMX_FN_LAST && PMX_FN_OUT_MASK[mode_r[i].func]) begin
        if (PMX_FN_OD_MASK[mode_r[i].func]) begin
          // open drain: only a low is driven, pull stays as set
          pad_nxt[i].oe_n = periph_drive[mode_r[i].func]; // [RULE1]
        end else begin
          // push-pull peripheral output, no resistor
          pad_nxt[i].dout = periph_drive[mode_r[i].func]; // [RULE1]
          pad_nxt[i].oe_n = 1'b0;
          pad_nxt[i].pull_up = 1'b0;
          pad_nxt[i].pull_down = 1'b0;
        end
      end
    end
  end

  // pad controls registered straight to the outputs
  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      for (int i = 0; i < PINS; i++) begin
        pad_ctl[i].dout <= 1'b0;
        pad_ctl[i].oe_n <= 1'b1;
        pad_ctl[i].pull_up <= 1'b0;
        pad_ctl[i].pull_down <= 1'b1;
        pad_ctl[i].analog_sel <= 1'b0;
      end
    end else begin
      pad_ctl <= pad_nxt;
    end
  end

  // input arbitration: lowest pin of port zero first, then port one
  always_comb begin
    sample_nxt = {32{PMX_IDLE_LEVEL}};
    claim_nxt = '0;
    for (int k = 0; k < 32; k++) begin
      if (PMX_FN_IN_MASK[k]) begin
        // scan downward so the lowest index is applied last and wins
        for (int i = PINS - 1; i >= 0; i--) begin
          if (mode_r[i].func == k[4:0]) begin
            sample_nxt[k] = pin_q_r[i]; // [RULE4]
            claim_nxt[k] = 1'b1;
          end
        end
        // port one only when no port zero pin carries the function
        if (!claim_nxt[k] && port_one_claim[k]) begin
          sample_nxt[k] = port_one_value[k]; // [RULE5]
          claim_nxt[k] = 1'b1;
        end
      end
    end
  end

  // arbitrated peripheral inputs registered to the outputs
  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      periph_sample <= {32{PMX_IDLE_LEVEL}};
      periph_claimed <= '0;
    end else begin
      periph_sample <= sample_nxt;
      periph_claimed <= claim_nxt;
    end
  end

  // checks on pins 0 to 3 and on arbitration
  sequence s_port_out0;
    mode_r[0].func == PMX_FN_PORT && mode_r[0].pull == PMX_PULL_OUT;
  endsequence

  sequence s_read0;
    reg_rd && reg_addr == PMX_OFF_PIN0_MODE;
  endsequence

  property p_port_out;
    @(posedge clk) disable iff (!rst_n_q)
      s_port_out0 |=> !pad_ctl[0].oe_n && pad_ctl[0].dout == $past(port_out_data[0]);
  endproperty
  a_port_out: assert property (p_port_out) else $error("port output not driven"); // [RULE1]

  property p_analog;
    @(posedge clk) disable iff (!rst_n_q)
      mode_r[0].func == PMX_FN_ANALOG |=> pad_ctl[0].analog_sel && pad_ctl[0].oe_n;
  endproperty
  a_analog: assert property (p_analog) else $error("analog select missing"); // [RULE2]

  property p_diag;
    @(posedge clk) disable iff (!rst_n_q)
      mode_r[1].func == PMX_FN_DIAG |=> !pad_ctl[1].oe_n && pad_ctl[1].dout == $past(radio_diag_output[1]);
  endproperty
  a_diag: assert property (p_diag) else $error("diagnostic not driven"); // [RULE3]

  property p_lowest;
    @(posedge clk) disable iff (!rst_n_q)
      mode_r[1].func == 5'h01 && mode_r[3].func == 5'h01 && mode_r[0].func != 5'h01
      |=> periph_sample[1] == $past(pin_q_r[1]);
  endproperty
  a_lowest: assert property (p_lowest) else $error("lowest pin lost arbitration"); // [RULE4]

  property p_port_zero_first;
    @(posedge clk) disable iff (!rst_n_q)
      mode_r[3].func == 5'h05 && port_one_claim[5] && mode_r[0].func != 5'h05 && mode_r[1].func != 5'h05
      && mode_r[2].func != 5'h05 |=> periph_sample[5] == $past(pin_q_r[3]);
  endproperty
  a_port_zero_first: assert property (p_port_zero_first) else $error("port one beat port zero"); // [RULE5]

  property p_no_pull;
    @(posedge clk) disable iff (!rst_n_q)
      mode_r[0].func == PMX_FN_PORT && mode_r[0].pull == PMX_PULL_NONE
      |=> pad_ctl[0].oe_n && !pad_ctl[0].pull_up && !pad_ctl[0].pull_down;
  endproperty
  a_no_pull: assert property (p_no_pull) else $error("floating input has a resistor"); // [RULE6]

  property p_pull_up;
    @(posedge clk) disable iff (!rst_n_q)
      mode_r[0].func == PMX_FN_PORT && mode_r[0].pull == PMX_PULL_UP
      |=> pad_ctl[0].oe_n && pad_ctl[0].pull_up && !pad_ctl[0].pull_down;
  endproperty
  a_pull_up: assert property (p_pull_up) else $error("pull-up not applied"); // [RULE7]

  property p_pull_down;
    @(posedge clk) disable iff (!rst_n_q)
      mode_r[0].func == PMX_FN_PORT && mode_r[0].pull == PMX_PULL_DOWN
      |=> pad_ctl[0].oe_n && pad_ctl[0].pull_down && !pad_ctl[0].pull_up;
  endproperty
  a_pull_down: assert property (p_pull_down) else $error("pull-down not applied"); // [RULE8]

  property p_out_no_pull;
    @(posedge clk) disable iff (!rst_n_q)
      s_port_out0 |=> !pad_ctl[0].pull_up && !pad_ctl[0].pull_down;
  endproperty
  a_out_no_pull: assert property (p_out_no_pull) else $error("output has a resistor"); // [RULE9]

  property p_analog_ignores_pull;
    @(posedge clk) disable iff (!rst_n_q)
      mode_r[3].func == PMX_FN_ANALOG && mode_r[3].pull == PMX_PULL_OUT
      |=> pad_ctl[3].oe_n && !pad_ctl[3].pull_up && !pad_ctl[3].pull_down;
  endproperty
  a_analog_ignores_pull: assert property (p_analog_ignores_pull) else $error("pull field used in analog"); // [RULE10]

  property p_reserved_zero;
    @(posedge clk) disable iff (!rst_n_q)
      s_read0 |=> reg_rdata[15:10] == 6'h00 && reg_rdata[7:5] == 3'h0 && reg_rdata[4:0] == $past(mode_r[0].func);
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits not zero"); // [RULE11]

  // pin 2 carries an open-drain peripheral output
  sequence s_od2;
    mode_r[2].func inside {5'h09, 5'h0A};
  endsequence

  // pin 2 carries a push-pull peripheral output
  sequence s_push2;
    mode_r[2].func inside {5'h02, 5'h04, 5'h06, 5'h07, 5'h08, 5'h0C, 5'h0E, 5'h10, 5'h11, 5'h14, 5'h16, 5'h17,
      5'h18, 5'h19};
  endsequence

  // write strobe aimed at pin 0's register
  sequence s_write0;
    reg_wr && reg_addr == PMX_OFF_PIN0_MODE;
  endsequence

  // input code 13 carried by no pin of either port
  sequence s_free13;
    mode_r[0].func != 5'h0D && mode_r[1].func != 5'h0D && mode_r[2].func != 5'h0D && mode_r[3].func != 5'h0D
      && !port_one_claim[13];
  endsequence

  property p_open_drain;
    @(posedge clk) disable iff (!rst_n_q)
      s_od2 |=> !pad_ctl[2].dout && pad_ctl[2].oe_n == $past(periph_drive[mode_r[2].func]);
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("open-drain pin drives high"); // [RULE1]

  property p_push_pull;
    @(posedge clk) disable iff (!rst_n_q)
      s_push2 |=> !pad_ctl[2].oe_n && !pad_ctl[2].pull_up && !pad_ctl[2].pull_down
      && pad_ctl[2].dout == $past(periph_drive[mode_r[2].func]);
  endproperty
  a_push_pull: assert property (p_push_pull) else $error("peripheral output not driven"); // [RULE1]

  property p_read_idle;
    @(posedge clk) disable iff (!rst_n_q)
      !reg_rd |=> reg_rdata == 16'h0000;
  endproperty
  a_read_idle: assert property (p_read_idle) else $error("read data outside read cycle"); // [RULE11]

  property p_write0;
    @(posedge clk) disable iff (!rst_n_q)
      s_write0 |=> mode_r[0].func == $past(reg_wdata[PMX_FUNC_MSB:PMX_FUNC_LSB])
      && mode_r[0].pull == $past(reg_wdata[PMX_PULL_MSB:PMX_PULL_LSB]);
  endproperty
  a_write0: assert property (p_write0) else $error("mode write not taken"); // [RULE11]

  property p_idle_input;
    @(posedge clk) disable iff (!rst_n_q)
      s_free13 |=> periph_sample[13] == PMX_IDLE_LEVEL && !periph_claimed[13];
  endproperty
  a_idle_input: assert property (p_idle_input) else $error("unclaimed input not idle"); // [RULE5]

  property p_port_one_used;
    @(posedge clk) disable iff (!rst_n_q)
      mode_r[0].func != 5'h03 && mode_r[1].func != 5'h03 && mode_r[2].func != 5'h03 && mode_r[3].func != 5'h03
      && port_one_claim[3] |=> periph_sample[3] == $past(port_one_value[3]);
  endproperty
  a_port_one_used: assert property (p_port_one_used) else $error("port one input not taken"); // [RULE5]

  property p_diag_no_pull;
    @(posedge clk) disable iff (!rst_n_q)
      mode_r[1].func == PMX_FN_DIAG
      |=> !pad_ctl[1].pull_up && !pad_ctl[1].pull_down && !pad_ctl[1].analog_sel;
  endproperty
  a_diag_no_pull: assert property (p_diag_no_pull) else $error("diagnostic pin has a resistor"); // [RULE3]

endmodule

// ==== pmx_pkg.sv ====
package pmx_pkg;

  // register byte addresses on the plain register port
  localparam logic [31:0] PMX_OFF_PIN0_MODE = 32'h5000_3006;
  localparam logic [31:0] PMX_OFF_PIN1_MODE = 32'h5000_3008;
  localparam logic [31:0] PMX_OFF_PIN2_MODE = 32'h5000_300A;
  localparam logic [31:0] PMX_OFF_PIN3_MODE = 32'h5000_300C;
  // spacing between neighbouring mode registers
  localparam logic [31:0] PMX_OFF_STEP = 32'h0000_0002;

  // field positions inside a mode register
  localparam int PMX_FUNC_LSB = 0;
  localparam int PMX_FUNC_MSB = 4;
  localparam int PMX_PULL_LSB = 8;
  localparam int PMX_PULL_MSB = 9;

  // pull direction encodings
  localparam logic [1:0] PMX_PULL_NONE = 2'h0;
  localparam logic [1:0] PMX_PULL_UP = 2'h1;
  localparam logic [1:0] PMX_PULL_DOWN = 2'h2;
  localparam logic [1:0] PMX_PULL_OUT = 2'h3;

  // pin function codes with special handling
  localparam logic [4:0] PMX_FN_PORT = 5'h00;
  localparam logic [4:0] PMX_FN_ANALOG = 5'h0F;
  localparam logic [4:0] PMX_FN_DIAG = 5'h12;
  localparam logic [4:0] PMX_FN_LAST = 5'h19;

  // function codes that feed a peripheral input (receive, data in, clear to send, i2c lines)
  localparam logic [31:0] PMX_FN_IN_MASK = 32'h0028_2E2A;
  // function codes driven by a peripheral (transmit, spi out, pwm, request to send, i2c lines)
  localparam logic [31:0] PMX_FN_OUT_MASK = 32'h03D7_57D4;
  // function codes whose driver is open drain (i2c clock and data)
  localparam logic [31:0] PMX_FN_OD_MASK = 32'h0000_0600;
  // value a peripheral input sees when no pin carries it
  localparam logic PMX_IDLE_LEVEL = 1'b1;

  // reset state of a mode register: port function, pulled-down input
  localparam logic [4:0] PMX_RST_FUNC = PMX_FN_PORT;
  localparam logic [1:0] PMX_RST_PULL = PMX_PULL_DOWN;

  // stored part of one mode register; reserved bits are not kept
  typedef struct packed {
    logic [1:0] pull;
    logic [4:0] func;
  } pmx_mode_t;

  // per-pin pad controls
  typedef struct packed {
    logic dout;
    logic oe_n;
    logic pull_up;
    logic pull_down;
    logic analog_sel;
  } pmx_pad_t;

endpackage

// ==== pmx_pad_model.sv ====
`timescale 1ns/100ps
// far side of the pins: external drivers, weak resistors, floating pads
module pmx_pad_model (
  input wire logic clk,
  input wire pmx_pkg::pmx_pad_t [3:0] pad_ctl,
  input wire logic [3:0] ext_en,
  input wire logic [3:0] ext_drv,
  output logic [3:0] pad_in
);
  import pmx_pkg::*;
  logic [3:0] float_r; // level seen on an undriven, unpulled pin
  initial float_r = 4'hA;
  // a floating pin wanders so that it never passes for a held level
  always @(posedge clk) begin
    float_r <= ~float_r;
  end
  // external driver wins, then the pad driver, then the resistors
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      if (ext_en[i]) begin
        pad_in[i] = ext_drv[i];
      end else if (!pad_ctl[i].oe_n) begin
        pad_in[i] = pad_ctl[i].dout;
      end else if (pad_ctl[i].pull_up) begin
        pad_in[i] = 1'b1;
      end else if (pad_ctl[i].pull_down) begin
        pad_in[i] = 1'b0;
      end else begin
        pad_in[i] = float_r[i];
      end
    end
  end
endmodule

// ==== tb_top.sv ====
`timescale 1ns/100ps
module tb_top;
  import pmx_pkg::*;
  logic clk, nrst, reg_wr, reg_rd, b;
  logic [31:0] reg_addr, periph_drive, port_one_claim, port_one_value, periph_sample, periph_claimed;
  logic [15:0] reg_wdata, reg_rdata, rd_v, lfsr;
  logic [3:0] pad_in, port_out_data, port_in_data, radio_diag_output, ext_en, ext_drv;
  logic [4:0] c;
  pmx_pad_t [3:0] pad_ctl;
  int miscompares, comparisons, cycles;
  int outs [14] = '{2, 4, 6, 7, 8, 12, 14, 16, 17, 20, 22, 23, 24, 25}; // push-pull output codes
  int ins [7] = '{1, 3, 5, 11, 13, 19, 21}; // input codes
  pmx_port0_mux uut (.clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pad_in(pad_in), .pad_ctl(pad_ctl), .port_out_data(port_out_data),
    .port_in_data(port_in_data), .periph_drive(periph_drive), .radio_diag_output(radio_diag_output),
    .port_one_claim(port_one_claim), .port_one_value(port_one_value), .periph_sample(periph_sample),
    .periph_claimed(periph_claimed));
  pmx_pad_model pads (.clk(clk), .pad_ctl(pad_ctl), .ext_en(ext_en), .ext_drv(ext_drv), .pad_in(pad_in));
  // free-running clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // pseudo-random source
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // expected {oe_n, pull_up, pull_down, analog_sel}
  function automatic logic [3:0] exp_ctl(input logic [1:0] pull, input logic analog, input logic drive);
    if (analog) return 4'h9;
    if (drive || pull == PMX_PULL_OUT) return 4'h0;
    return {1'b1, pull == PMX_PULL_UP, pull == PMX_PULL_DOWN, 1'b0};
  endfunction
  function automatic logic [3:0] ctl_of(input pmx_pad_t p);
    return {p.oe_n, p.pull_up, p.pull_down, p.analog_sel};
  endfunction
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [31:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [31:0] a, output logic [15:0] d);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    d = reg_rdata;
  endtask
  // fresh random values on the peripheral, port and radio diagnostic inputs
  task automatic stir();
    logic [15:0] l1;
    l1 = lfsr_next(lfsr);
    lfsr = lfsr_next(l1);
    @(posedge clk);
    periph_drive <= {l1, lfsr};
    port_out_data <= l1[3:0];
    radio_diag_output <= lfsr[7:4];
    b = l1[9];
  endtask
  task automatic settle();
    repeat (6) @(posedge clk);
    #1;
  endtask
  task automatic conclude();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      conclude();
    end
  end
  initial begin
    {nrst, reg_wr, reg_rd, reg_addr, reg_wdata, periph_drive, port_one_claim, port_one_value} = '0;
    {port_out_data, radio_diag_output, ext_en, ext_drv, b} = '0;
    lfsr = 16'h0C6F;
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    repeat (4) @(posedge clk);
    for (int i = 0; i < 4; i++) begin
      rd(PMX_OFF_PIN0_MODE + PMX_OFF_STEP * i, rd_v);
      chk(rd_v, 16'h0200);
      chk(16'(ctl_of(pad_ctl[i])), 16'h000A);
    end
    wr(PMX_OFF_PIN0_MODE, 16'hFFFF);
    wr(32'h5000_3004, 16'h0301);
    rd(PMX_OFF_PIN0_MODE, rd_v);
    chk(rd_v, 16'h031F);
    @(negedge clk);
    chk(reg_rdata, 16'h0000);
    rd(32'h5000_3004, rd_v);
    chk(rd_v, 16'h0000);
    for (int p = 0; p < 4; p++) begin
      wr(PMX_OFF_PIN0_MODE, {6'h00, 2'(p), 8'h00});
      stir();
      settle();
      chk(16'(ctl_of(pad_ctl[0])), 16'(exp_ctl(2'(p), 1'b0, 1'b0)));
      if (p == 3) chk(16'(pad_ctl[0].dout), 16'(port_out_data[0]));
    end
    for (int i = 0; i < 4; i++) begin
      wr(PMX_OFF_PIN0_MODE + PMX_OFF_STEP * i, i[0] ? 16'h030F : 16'h010F);
      settle();
      chk(16'(ctl_of(pad_ctl[i])), 16'(exp_ctl(2'h1, 1'b1, 1'b0)));
      wr(PMX_OFF_PIN0_MODE + PMX_OFF_STEP * i, 16'h0012);
      stir();
      settle();
      chk(16'(ctl_of(pad_ctl[i])), 16'h0000);
      chk(16'(pad_ctl[i].dout), 16'(radio_diag_output[i]));
    end
    for (int k = 0; k < 14; k++) begin
      wr(PMX_OFF_PIN2_MODE, {11'h000, 5'(outs[k])});
      stir();
      settle();
      chk(16'(ctl_of(pad_ctl[2])), 16'h0000);
      chk(16'(pad_ctl[2].dout), 16'(periph_drive[outs[k]]));
    end
    for (int k = 9; k < 11; k++) begin
      wr(PMX_OFF_PIN2_MODE, {6'h00, PMX_PULL_UP, 3'h0, 5'(k)});
      stir();
      settle();
      chk(16'({pad_ctl[2].dout, ctl_of(pad_ctl[2])}), 16'({1'b0, periph_drive[k], 3'h4}));
      chk(16'(periph_sample[k]), 16'(periph_drive[k]));
    end
    wr(PMX_OFF_PIN0_MODE, 16'h0200);
    wr(PMX_OFF_PIN2_MODE, 16'h0200);
    ext_en <= 4'hA;
    for (int k = 0; k < 7; k++) begin
      c = 5'(ins[k]);
      wr(PMX_OFF_PIN1_MODE, {11'h000, c});
      wr(PMX_OFF_PIN3_MODE, {11'h000, c});
      stir();
      ext_drv <= {~b, 1'b0, b, 1'b0};
      port_one_value <= {32{b}};
      port_one_claim <= 32'hFFFF_FFFF;
      settle();
      chk(16'(periph_sample[c]), 16'(b));
      chk(16'(periph_claimed[c]), 16'h0001);
      chk(16'(port_in_data), 16'({~b, 1'b0, b, 1'b0}));
      wr(PMX_OFF_PIN1_MODE, 16'h0200);
      settle();
      chk(16'(periph_sample[c]), {15'h0000, ~b});
      wr(PMX_OFF_PIN3_MODE, 16'h0200);
      settle();
      chk(16'(periph_sample[c]), 16'(b));
      @(posedge clk);
      port_one_claim <= 32'h0000_0000;
      settle();
      chk(16'(periph_sample[c]), 16'h0001);
    end
    conclude();
  end
endmodule
